// ---- rtl/cfgbk_pkg.sv ----
/*
  Constants, field layouts and carrier types for the global configuration
  register bank. Assumes an eight-bit index/data port pair on a host I/O bus.
*/
package cfgbk_pkg;

  // Global register indices
  localparam logic [7:0] CFGBK_IDX_CONFIG_CONTROL = 8'h02;
  localparam logic [7:0] CFGBK_IDX_RUN_INDEX_ADDRESS = 8'h03;
  localparam logic [7:0] CFGBK_IDX_UNIT_SELECT = 8'h07;
  localparam logic [7:0] CFGBK_IDX_DEVICE_IDENTITY = 8'h20;
  localparam logic [7:0] CFGBK_IDX_DEVICE_REVISION = 8'h21;
  localparam logic [7:0] CFGBK_IDX_UNIT_POWER_ENABLE = 8'h22;
  localparam logic [7:0] CFGBK_IDX_AUTO_POWER_MANAGEMENT = 8'h23;
  localparam logic [7:0] CFGBK_IDX_OSCILLATOR_SELECT = 8'h24;
  localparam logic [7:0] CFGBK_IDX_CONFIG_ADDRESS_LOW = 8'h26;
  localparam logic [7:0] CFGBK_IDX_CONFIG_ADDRESS_HIGH = 8'h27;
  localparam logic [7:0] CFGBK_IDX_CLOCK_OUTPUT_MASK = 8'h28;

  // Field positions and implemented-bit masks
  localparam int CFGBK_SOFT_RESET_BIT = 0;
  localparam int CFGBK_RUN_ACCESS_BIT = 7;
  localparam logic [7:0] CFGBK_RUN_INDEX_MASK = 8'h83;
  localparam logic [7:0] CFGBK_POWER_MASK = 8'h7f;
  localparam logic [7:0] CFGBK_APM_MASK = 8'h3f;
  localparam logic [7:0] CFGBK_OSC_MASK = 8'h05;
  localparam int CFGBK_OSC_HS_SEL_BIT = 0;
  localparam logic [7:0] CFGBK_ADDR_LOW_MASK = 8'hfe;
  localparam logic [7:0] CFGBK_CLOCK_MASK_MASK = 8'h1f;
  localparam int CFGBK_NUM_CLOCKS = 5;

  // Reset values
  localparam logic [7:0] CFGBK_RST_RUN_INDEX_ADDRESS = 8'h03;
  localparam logic [7:0] CFGBK_RST_UNIT_SELECT = 8'h00;
  localparam logic [7:0] CFGBK_RST_UNIT_POWER_ENABLE = 8'h00;
  localparam logic [7:0] CFGBK_RST_AUTO_POWER_MANAGEMENT = 8'h00;
  localparam logic [7:0] CFGBK_RST_OSCILLATOR_SELECT = 8'h04;
  localparam logic [7:0] CFGBK_RST_ADDR_LOW_STRAP_LOW = 8'hf0;
  localparam logic [7:0] CFGBK_RST_ADDR_LOW_STRAP_HIGH = 8'h70;
  localparam logic [7:0] CFGBK_RST_CONFIG_ADDRESS_HIGH = 8'h03;
  localparam logic [7:0] CFGBK_RST_CLOCK_OUTPUT_MASK = 8'h00;
  localparam logic [7:0] CFGBK_RST_INDEX = 8'h00;

  // Strap capture sequence, one-hot
  typedef enum logic [1:0] {
    CFGBK_ST_STRAP = 2'b01,
    CFGBK_ST_RUN = 2'b10
  } cfgbk_state_e;

  // One host bus cycle as seen by the bank
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cfgbk_host_req_s;

endpackage : cfgbk_pkg

// ---- rtl/cfgbk_port_decode.sv ----
/*
  Index/data port address decoder for the configuration port pair.
  Assumes the port base is even; index sits at the base, data one above.
*/
`timescale 1ns/10ps
`default_nettype none
module cfgbk_port_decode
  import cfgbk_pkg::*;
(
  input wire cfgbk_host_req_s req,
  input wire logic [15:0] port_base,
  output logic index_hit,
  output logic data_hit
);

  // Full sixteen-bit compare so the pair is not aliased
  always_comb begin
    index_hit = (req.addr == port_base);
    data_hit = (req.addr == (port_base | 16'h0001));
  end

endmodule : cfgbk_port_decode
`default_nettype wire

// ---- rtl/cfgbk_clock_gate.sv ----
/*
  Clock output masking: a masked clock stops and its pin is released.
  Assumes the source clocks are free running and supplied from outside.
*/
`timescale 1ns/10ps
`default_nettype none
module cfgbk_clock_gate
  import cfgbk_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [CFGBK_NUM_CLOCKS-1:0] mask,
  input wire logic [CFGBK_NUM_CLOCKS-1:0] clk_src,
  output logic [CFGBK_NUM_CLOCKS-1:0] clk_out,
  output logic [CFGBK_NUM_CLOCKS-1:0] clk_oe
);

  logic [CFGBK_NUM_CLOCKS-1:0] oe_q;
  logic [CFGBK_NUM_CLOCKS-1:0] oe_d;

  // Enable follows the inverted mask register one cycle later
  always_comb begin
    oe_d = ~mask;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oe_q <= '0;
    end else begin
      oe_q <= oe_d;
    end
  end

  // Masked clocks are held low and released
  always_comb begin
    clk_out = clk_src & oe_q;
    clk_oe = oe_q;
  end

endmodule : cfgbk_clock_gate
`default_nettype wire

// ---- rtl/cfgbk_global_regs.sv ----
/*
  Global configuration register bank behind the configuration index/data pair.
  Assumes config_mode comes from the entry logic and sysopt is stable at reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cfgbk_global_regs
  import cfgbk_pkg::*;
#(
  parameter logic [7:0] DEVICE_IDENTITY = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_REVISION = 8'h0b, // Arbitrary value
  parameter logic HS_SEL_48MHZ_LEVEL = 1'b1,
  parameter logic [1:0] RUN_INDEX_ENCODING = 2'b00
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sysopt,
  input wire logic config_mode,
  input wire cfgbk_host_req_s host_req,
  output logic [7:0] host_rd_data,
  output logic host_rd_valid,
  output logic soft_reset_pulse,
  output logic run_gp_access_enable,
  output logic [1:0] run_index_select,
  output logic run_index_is_default,
  output logic [7:0] unit_select,
  output logic [6:0] unit_power_enable,
  output logic [5:0] auto_power_enable,
  output logic hs_clock_is_48mhz,
  output logic [15:0] config_port_base,
  input wire logic [CFGBK_NUM_CLOCKS-1:0] clk_src,
  output logic [CFGBK_NUM_CLOCKS-1:0] clk_out,
  output logic [CFGBK_NUM_CLOCKS-1:0] clk_oe
);

  logic [7:0] index_q, index_d;
  logic [7:0] runidx_q, runidx_d;
  logic [7:0] unitsel_q, unitsel_d;
  logic [7:0] pwr_q, pwr_d;
  logic [7:0] apm_q, apm_d;
  logic [7:0] osc_q, osc_d;
  logic [7:0] addrlo_q, addrlo_d;
  logic [7:0] addrhi_q, addrhi_d;
  logic [7:0] clkmask_q, clkmask_d;
  logic [15:0] base_q, base_d;
  logic soft_q, soft_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  cfgbk_state_e state_q, state_d;
  logic index_hit, data_hit;
  logic live, wr_index, wr_data, rd_any, soft_now;

  // Readback with implemented-bit masks; everything else reads zero
  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    case (idx)
      CFGBK_IDX_RUN_INDEX_ADDRESS: reg_read = runidx_q & CFGBK_RUN_INDEX_MASK;
      CFGBK_IDX_UNIT_SELECT: reg_read = unitsel_q;
      CFGBK_IDX_DEVICE_IDENTITY: reg_read = DEVICE_IDENTITY;
      CFGBK_IDX_DEVICE_REVISION: reg_read = DEVICE_REVISION;
      CFGBK_IDX_UNIT_POWER_ENABLE: reg_read = pwr_q & CFGBK_POWER_MASK;
      CFGBK_IDX_AUTO_POWER_MANAGEMENT: reg_read = apm_q & CFGBK_APM_MASK;
      CFGBK_IDX_OSCILLATOR_SELECT: reg_read = osc_q & CFGBK_OSC_MASK;
      CFGBK_IDX_CONFIG_ADDRESS_LOW: reg_read = addrlo_q & CFGBK_ADDR_LOW_MASK;
      CFGBK_IDX_CONFIG_ADDRESS_HIGH: reg_read = addrhi_q;
      CFGBK_IDX_CLOCK_OUTPUT_MASK: reg_read = clkmask_q & CFGBK_CLOCK_MASK_MASK;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  cfgbk_port_decode u_decode (
    .req(host_req),
    .port_base(base_q),
    .index_hit(index_hit),
    .data_hit(data_hit)
  );

  // Access qualification: only in configuration mode, after strap capture
  always_comb begin
    live = config_mode && (state_q == CFGBK_ST_RUN);
    wr_index = live && host_req.wr && index_hit;
    wr_data = live && host_req.wr && data_hit;
    rd_any = live && host_req.rd && (index_hit || data_hit);
    soft_now = wr_data && (index_q == CFGBK_IDX_CONFIG_CONTROL) && host_req.wdata[CFGBK_SOFT_RESET_BIT];
  end

  // Next values of the register file, strap capture and soft reset
  always_comb begin
    index_d = index_q;
    runidx_d = runidx_q;
    unitsel_d = unitsel_q;
    pwr_d = pwr_q;
    apm_d = apm_q;
    osc_d = osc_q;
    addrlo_d = addrlo_q;
    addrhi_d = addrhi_q;
    clkmask_d = clkmask_q;
    base_d = base_q;
    state_d = state_q;
    soft_d = soft_now;
    case (state_q)
      CFGBK_ST_STRAP: begin
        addrlo_d = sysopt ? CFGBK_RST_ADDR_LOW_STRAP_HIGH : CFGBK_RST_ADDR_LOW_STRAP_LOW;
        base_d = {addrhi_q, addrlo_d};
        state_d = CFGBK_ST_RUN;
      end
      CFGBK_ST_RUN: begin
        if (wr_index) begin
          index_d = host_req.wdata;
        end
        if (soft_now) begin
          // Soft reset leaves the port address alone
          runidx_d = CFGBK_RST_RUN_INDEX_ADDRESS;
          unitsel_d = CFGBK_RST_UNIT_SELECT;
          pwr_d = CFGBK_RST_UNIT_POWER_ENABLE;
          apm_d = CFGBK_RST_AUTO_POWER_MANAGEMENT;
          osc_d = CFGBK_RST_OSCILLATOR_SELECT;
          clkmask_d = CFGBK_RST_CLOCK_OUTPUT_MASK;
        end else if (wr_data) begin
          case (index_q)
            CFGBK_IDX_RUN_INDEX_ADDRESS: runidx_d = host_req.wdata & CFGBK_RUN_INDEX_MASK;
            CFGBK_IDX_UNIT_SELECT: unitsel_d = host_req.wdata;
            CFGBK_IDX_UNIT_POWER_ENABLE: pwr_d = host_req.wdata & CFGBK_POWER_MASK;
            CFGBK_IDX_AUTO_POWER_MANAGEMENT: apm_d = host_req.wdata & CFGBK_APM_MASK;
            CFGBK_IDX_OSCILLATOR_SELECT: osc_d = host_req.wdata & CFGBK_OSC_MASK;
            CFGBK_IDX_CONFIG_ADDRESS_LOW: addrlo_d = host_req.wdata & CFGBK_ADDR_LOW_MASK;
            CFGBK_IDX_CONFIG_ADDRESS_HIGH: begin
              addrhi_d = host_req.wdata;
              base_d = {host_req.wdata, addrlo_q & CFGBK_ADDR_LOW_MASK};
            end
            CFGBK_IDX_CLOCK_OUTPUT_MASK: clkmask_d = host_req.wdata & CFGBK_CLOCK_MASK_MASK;
            default: begin end
          endcase
        end
      end
      default: state_d = CFGBK_ST_STRAP;
    endcase
  end

  // Register file; hard reset loads every documented default
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      index_q <= CFGBK_RST_INDEX;
      runidx_q <= CFGBK_RST_RUN_INDEX_ADDRESS;
      unitsel_q <= CFGBK_RST_UNIT_SELECT;
      pwr_q <= CFGBK_RST_UNIT_POWER_ENABLE;
      apm_q <= CFGBK_RST_AUTO_POWER_MANAGEMENT;
      osc_q <= CFGBK_RST_OSCILLATOR_SELECT;
      addrlo_q <= CFGBK_RST_ADDR_LOW_STRAP_LOW;
      addrhi_q <= CFGBK_RST_CONFIG_ADDRESS_HIGH;
      clkmask_q <= CFGBK_RST_CLOCK_OUTPUT_MASK;
      base_q <= {CFGBK_RST_CONFIG_ADDRESS_HIGH, CFGBK_RST_ADDR_LOW_STRAP_LOW};
      soft_q <= 1'b0;
      state_q <= CFGBK_ST_STRAP;
    end else begin
      index_q <= index_d;
      runidx_q <= runidx_d;
      unitsel_q <= unitsel_d;
      pwr_q <= pwr_d;
      apm_q <= apm_d;
      osc_q <= osc_d;
      addrlo_q <= addrlo_d;
      addrhi_q <= addrhi_d;
      clkmask_q <= clkmask_d;
      base_q <= base_d;
      soft_q <= soft_d;
      state_q <= state_d;
    end
  end

  // Read answer: index port returns the index, data port the selection
  always_comb begin
    rvalid_d = rd_any;
    rdata_d = rdata_q;
    if (rd_any) begin
      rdata_d = index_hit ? index_q : reg_read(index_q);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  cfgbk_clock_gate u_clocks (
    .clock(clock),
    .rst(rst),
    .mask(clkmask_q[CFGBK_NUM_CLOCKS-1:0]),
    .clk_src(clk_src),
    .clk_out(clk_out),
    .clk_oe(clk_oe)
  );

  // Control outputs to the units and the run-mode port logic
  always_comb begin
    host_rd_data = rdata_q;
    host_rd_valid = rvalid_q;
    soft_reset_pulse = soft_q;
    run_gp_access_enable = runidx_q[CFGBK_RUN_ACCESS_BIT];
    run_index_select = runidx_q[1:0];
    run_index_is_default = (runidx_q[1:0] == RUN_INDEX_ENCODING);
    unit_select = unitsel_q;
    unit_power_enable = pwr_q[6:0];
    auto_power_enable = apm_q[5:0];
    hs_clock_is_48mhz = (osc_q[CFGBK_OSC_HS_SEL_BIT] == HS_SEL_48MHZ_LEVEL);
    config_port_base = base_q;
  end

  // Assertions share the bank clock; hard reset switches them off
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Soft reset, mode, port address, readback and output checks

  AST_SOFT_RESET_CLEARS: assert property (soft_now |=> (pwr_q == 8'h00) && (osc_q == 8'h04) && soft_q ##1 !soft_q)
    else $error("soft reset did not load defaults or did not self-clear");
  AST_SOFT_KEEPS_PORT: assert property (soft_now |=> $stable(base_q) && $stable(addrhi_q))
    else $error("soft reset disturbed the configuration port address");
  AST_NO_RUN_WRITE: assert property (!config_mode && host_req.wr |=> $stable(index_q) && $stable(pwr_q))
    else $error("write reached the bank outside configuration mode");
  AST_NO_RUN_READ: assert property (!config_mode |=> !rvalid_q)
    else $error("read answered outside configuration mode");
  AST_ID_READ: assert property (rd_any && data_hit && index_q == CFGBK_IDX_DEVICE_IDENTITY
    |=> host_rd_valid && host_rd_data == DEVICE_IDENTITY)
    else $error("identity read returned a wrong value");
  AST_RESERVED_ZERO: assert property (rd_any && data_hit && (index_q < 8'h02 || index_q == 8'h25 || index_q > 8'h28)
    |=> host_rd_data == 8'h00)
    else $error("reserved location did not read zero");
  AST_HIGH_MOVES_PORT: assert property (wr_data && !soft_now && index_q == CFGBK_IDX_CONFIG_ADDRESS_HIGH
    |=> base_q == {$past(host_req.wdata), addrlo_q})
    else $error("high byte write did not move the port");
  AST_LOW_HOLDS_PORT: assert property (wr_data && index_q == CFGBK_IDX_CONFIG_ADDRESS_LOW |=> $stable(base_q))
    else $error("low byte write moved the port early");
  AST_POWER_BIT7: assert property (rd_any && data_hit && index_q == CFGBK_IDX_UNIT_POWER_ENABLE
    |=> host_rd_data[7] == 1'b0)
    else $error("power register bit 7 read as one");
  AST_CLOCK_RELEASE: assert property (clkmask_q[4] ##1 clkmask_q[4] |-> !clk_oe[4] && !clk_out[4])
    else $error("masked clock still driven");
  AST_RUN_ENABLE: assert property (wr_data && !soft_now && index_q == CFGBK_IDX_RUN_INDEX_ADDRESS
    |=> run_gp_access_enable == $past(host_req.wdata[7]) && runidx_q[6:2] == 5'h00)
    else $error("run-mode access enable not taken from bit 7");

  // Decode, unit selection and read answer
  AST_INDEX_FULL: assert property (wr_index |=> index_q == $past(host_req.wdata))
    else $error("index write did not keep all eight bits");
  AST_DATA_READ_VALID: assert property (rd_any |=> host_rd_valid)
    else $error("accepted read gave no valid answer");
  AST_UNIT_SELECT: assert property (wr_data && index_q == CFGBK_IDX_UNIT_SELECT
    |=> unit_select == $past(host_req.wdata))
    else $error("unit select write not taken");
  AST_REV_READ: assert property (rd_any && data_hit && index_q == CFGBK_IDX_DEVICE_REVISION
    |=> host_rd_valid && host_rd_data == DEVICE_REVISION)
    else $error("revision read returned a wrong value");
  AST_APM_TOP_ZERO: assert property (rd_any && data_hit && index_q == CFGBK_IDX_AUTO_POWER_MANAGEMENT
    |=> host_rd_data[7:6] == 2'b00)
    else $error("power management bits 7:6 read as nonzero");
  AST_OSC_BITS: assert property (rd_any && data_hit && index_q == CFGBK_IDX_OSCILLATOR_SELECT
    |=> (host_rd_data & ~CFGBK_OSC_MASK) == 8'h00)
    else $error("oscillator register read back an unimplemented bit");
  AST_MASK_UPPER_ZERO: assert property (rd_any && data_hit && index_q == CFGBK_IDX_CLOCK_OUTPUT_MASK
    |=> host_rd_data[7:5] == 3'h0)
    else $error("clock mask bits 7:5 read as nonzero");

  // Hard reset defaults, seen in the strap cycle, and strap capture, seen one cycle later
  AST_HARD_DEFAULTS: assert property (state_q == CFGBK_ST_STRAP
    |-> runidx_q == CFGBK_RST_RUN_INDEX_ADDRESS && osc_q == CFGBK_RST_OSCILLATOR_SELECT
    && addrhi_q == CFGBK_RST_CONFIG_ADDRESS_HIGH)
    else $error("hard reset left a register off its default");
  AST_STRAP_CAPTURE: assert property (state_q == CFGBK_ST_STRAP
    |=> addrlo_q == ($past(sysopt) ? CFGBK_RST_ADDR_LOW_STRAP_HIGH : CFGBK_RST_ADDR_LOW_STRAP_LOW))
    else $error("strap level not captured into the address low byte");

  // Main scenarios
  COV_SOFT_RESET: cover property (soft_now ##1 soft_reset_pulse);
  COV_PORT_MOVE: cover property (wr_data && index_q == CFGBK_IDX_CONFIG_ADDRESS_HIGH);
  COV_ID_READ: cover property (rd_any && data_hit && index_q == CFGBK_IDX_DEVICE_IDENTITY);
  COV_MODE_REFUSED: cover property (!config_mode && host_req.wr);
  COV_STRAP_HIGH: cover property (state_q == CFGBK_ST_STRAP && sysopt);

endmodule : cfgbk_global_regs
`default_nettype wire

// ---- dv/cfgbk_host_model.sv ----
/*
  Host processor model: drives index/data port cycles on the host request.
  Assumes the testbench gives it the live configuration port base.
*/
`timescale 1ns/10ps
`default_nettype none
module cfgbk_host_model
  import cfgbk_pkg::*;
(
  input wire logic clock,
  input wire logic [15:0] base,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output var cfgbk_host_req_s req
);
  // Idle bus at time zero
  initial begin
    req = '0;
  end

  // One cycle: driven after a falling edge, held over the rising edge
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
    @(negedge clock);
    req = '{addr: a, wdata: d, wr: w, rd: r};
    @(negedge clock);
    req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0}; // Released bus keeps no stale value
  endtask : cycle

  // Register number to the index port first, then the data port
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    cycle(base, idx, 1'b1, 1'b0);
    cycle({base[15:1], 1'b1}, d, 1'b1, 1'b0);
  endtask : wr_reg

  // Read answer is taken one cycle after the data port read
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d, output logic v);
    cycle(base, idx, 1'b1, 1'b0);
    cycle({base[15:1], 1'b1}, 8'h00, 1'b0, 1'b1);
    d = rd_data;
    v = rd_valid;
  endtask : rd_reg
endmodule : cfgbk_host_model
`default_nettype wire

// ---- dv/cfgbk_global_regs_tb_top.sv ----
/*
  Self-checking testbench for the global configuration register bank.
  Assumes the host model is compiled first and the package is available.
*/
`timescale 1ns/10ps
`default_nettype none
module cfgbk_global_regs_tb_top;
  import cfgbk_pkg::*;
  localparam logic [7:0] ID_CODE = 8'h6c; // Arbitrary value
  localparam logic [7:0] REV_CODE = 8'h02; // Arbitrary value
  logic clock, rst, sysopt, config_mode, rd_valid, soft_pulse, run_en, run_def, hs48;
  logic [15:0] host_base, port_base;
  logic [7:0] rd_data, unit;
  logic [1:0] run_sel;
  logic [6:0] pwr;
  logic [5:0] apm;
  logic [4:0] clk_src, clk_out, clk_oe;
  cfgbk_host_req_s host_req;
  int n_mismatch = 0;
  int checks = 0;
  int n_pulse = 0;

  cfgbk_global_regs #(.DEVICE_IDENTITY(ID_CODE), .DEVICE_REVISION(REV_CODE)) DUT (
    .clock(clock), .rst(rst), .sysopt(sysopt), .config_mode(config_mode), .host_req(host_req),
    .host_rd_data(rd_data), .host_rd_valid(rd_valid), .soft_reset_pulse(soft_pulse),
    .run_gp_access_enable(run_en), .run_index_select(run_sel), .run_index_is_default(run_def),
    .unit_select(unit), .unit_power_enable(pwr), .auto_power_enable(apm), .hs_clock_is_48mhz(hs48),
    .config_port_base(port_base), .clk_src(clk_src), .clk_out(clk_out), .clk_oe(clk_oe)
  );

  cfgbk_host_model host (
    .clock(clock), .base(host_base), .rd_data(rd_data), .rd_valid(rd_valid), .req(host_req)
  );

  // Clock at 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Counts soft reset pulses seen by the units
  always @(posedge clock) begin
    if (soft_pulse === 1'b1) n_pulse <= n_pulse + 1;
  end

  // Compare of any value, zero extended
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Read one register and compare valid and data
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd_reg(idx, d, v);
    chk("read valid", 16'(1'b1), 16'(v));
    chk($sformatf("register %h", idx), 16'(e), 16'(d));
  endtask : rd_chk

  // Hard reset with a given strap level
  task automatic do_reset(input logic s);
    @(negedge clock);
    rst = 1'b1;
    sysopt = s;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    host_base = s ? 16'h0370 : 16'h03f0;
    repeat (2) @(negedge clock);
  endtask : do_reset

  // Defaults at the ports and through reads
  task automatic t_defaults;
    logic [7:0] idx [8] = '{8'h03, 8'h07, 8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h28};
    logic [7:0] dft [8] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h04, 8'hf0, 8'h03, 8'h00};
    chk("port base", 16'h03f0, port_base);
    chk("run select", 16'(2'd3), 16'(run_sel));
    chk("clock enables", 16'(5'h1f), 16'(clk_oe));
    chk("high speed select", 16'(1'b0), 16'(hs48));
    for (int i = 0; i < 8; i++) rd_chk(idx[i], dft[i]);
  endtask : t_defaults

  // All ones written, implemented bits only read back
  task automatic t_rw;
    logic [7:0] idx [6] = '{8'h03, 8'h07, 8'h22, 8'h23, 8'h24, 8'h28};
    logic [7:0] msk [6] = '{8'h83, 8'hff, 8'h7f, 8'h3f, 8'h05, 8'h1f};
    for (int i = 0; i < 6; i++) begin
      host.wr_reg(idx[i], 8'hff);
      rd_chk(idx[i], msk[i]);
    end
    chk("run access", 16'(1'b1), 16'(run_en));
    chk("unit", 16'h00ff, 16'(unit));
    chk("power", 16'h007f, 16'(pwr));
    chk("auto power", 16'h003f, 16'(apm));
    chk("high speed select", 16'(1'b1), 16'(hs48));
    chk("masked outputs", 16'(5'h00), 16'({clk_oe, clk_out}));
    host.wr_reg(8'h03, 8'h80);
    rd_chk(8'h03, 8'h80);
    chk("run select", 16'(2'd0), 16'(run_sel));
    chk("run default", 16'(1'b1), 16'(run_def));
    host.wr_reg(8'h28, 8'h08);
    rd_chk(8'h28, 8'h08);
    chk("clock enables", 16'(5'h17), 16'(clk_oe));
    chk("clock out", 16'(5'h15), 16'(clk_out));
    clk_src = 5'h0a;
    @(negedge clock);
    chk("clock out", 16'(5'h02), 16'(clk_out));
  endtask : t_rw

  // Reserved and read-only places, and upper index bits
  task automatic t_reserved;
    logic [7:0] idx [11] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h08, 8'h1f, 8'h25, 8'h29, 8'h2c, 8'h20, 8'h21};
    for (int i = 0; i < 11; i++) begin
      host.wr_reg(idx[i], 8'hff);
      rd_chk(idx[i], i == 9 ? ID_CODE : (i == 10 ? REV_CODE : 8'h00));
    end
    chk("power", 16'h007f, 16'(pwr));
    host.wr_reg(8'ha2, 8'h00);
    rd_chk(8'h22, 8'h7f);
  endtask : t_reserved

  // Outside configuration mode nothing is reached
  task automatic t_mode;
    logic [7:0] d;
    logic v;
    config_mode = 1'b0;
    host.wr_reg(8'h22, 8'h00);
    host.rd_reg(8'h22, d, v);
    chk("read valid", 16'(1'b0), 16'(v));
    config_mode = 1'b1;
    rd_chk(8'h22, 8'h7f);
  endtask : t_mode

  // Port moves on the high byte, then survives a soft reset
  task automatic t_move_soft;
    int p0;
    host.wr_reg(8'h26, 8'h61);
    rd_chk(8'h26, 8'h60);
    chk("port base", 16'h03f0, port_base);
    host.wr_reg(8'h27, 8'h12);
    chk("port base", 16'h1260, port_base);
    host_base = 16'h1260;
    rd_chk(8'h27, 8'h12);
    p0 = n_pulse;
    host.wr_reg(8'h02, 8'h01);
    chk("soft pulse", 16'(1'b1), 16'(soft_pulse));
    // The pulse is counted at the edge that ends it, one cycle later
    @(negedge clock);
    chk("soft pulses", 16'h0001, 16'(n_pulse - p0));
    chk("soft pulse", 16'(1'b0), 16'(soft_pulse));
    chk("power", 16'h0000, 16'(pwr));
    chk("unit", 16'h0000, 16'(unit));
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h03);
    rd_chk(8'h24, 8'h04);
    chk("port base", 16'h1260, port_base);
    rd_chk(8'h26, 8'h60);
  endtask : t_move_soft

  // Hard reset with the strap high restores the port
  task automatic t_strap;
    do_reset(1'b1);
    chk("port base", 16'h0370, port_base);
    rd_chk(8'h26, 8'h70);
    rd_chk(8'h27, 8'h03);
  endtask : t_strap

  // Final report and verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    rst = 1'b1;
    sysopt = 1'b0;
    config_mode = 1'b1;
    clk_src = 5'h15;
    host_base = 16'h03f0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    t_defaults;
    t_rw;
    t_reserved;
    t_mode;
    t_move_soft;
    t_strap;
    end_sim;
  end

  // Bound on the whole run
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    end_sim;
  end
endmodule : cfgbk_global_regs_tb_top
`default_nettype wire
